//--- src/fdm_consts.svh
`ifndef FDM_CONSTS_SVH
`define FDM_CONSTS_SVH

// word layout: one sign stage then the fraction stages
`define FDM_WORD_W     40
`define FDM_FRAC_W     39
`define FDM_SIGN_BIT   39

// singular words
`define FDM_ZERO       40'h00_0000_0000
`define FDM_NEG_ONE    40'h80_0000_0000
`define FDM_ALL_ONES   40'hFF_FFFF_FFFF
`define FDM_POS_MAX    40'h7F_FFFF_FFFF
`define FDM_NEG_UNIT   40'h80_0000_0001
`define FDM_LSB        40'h00_0000_0001

// exact even quotients of a negative dividend are lowered by two lsb of weight
`define FDM_EXACT_ADJ  40'h00_0000_0002

`endif

//--- src/fdm_pkg.sv
`include "fdm_consts.svh"

package fdm_pkg;

    typedef logic [`FDM_WORD_W-1:0] fdm_word_t;

    typedef enum logic {
        FDM_OP_MUL,
        FDM_OP_DIV
    } fdm_op_t;

    typedef enum logic [1:0] {
        FDM_ST_IDLE,
        FDM_ST_MUL,
        FDM_ST_DSTART,
        FDM_ST_DWAIT
    } fdm_state_t;

endpackage : fdm_pkg

//--- src/fdm_div_if.sv
// carries one magnitude division between the control and the engine
interface fdm_div_if #(
    parameter int FRAC_W = 39
);
    logic              start;
    logic [FRAC_W:0]   num_mag;
    logic [FRAC_W:0]   den_mag;
    logic              done;
    logic [FRAC_W-1:0] quot;
    logic              exact;

    modport ctrl (
        output start,
        output num_mag,
        output den_mag,
        input  done,
        input  quot,
        input  exact
    );

    modport engine (
        input  start,
        input  num_mag,
        input  den_mag,
        output done,
        output quot,
        output exact
    );
endinterface : fdm_div_if

//--- src/fdm_divider.sv
`include "fdm_consts.svh"

// restoring magnitude divider, one quotient stage per clock
module fdm_divider #(
    parameter int FRAC_W = `FDM_FRAC_W
) (
    input  wire logic  clk_sys_i,
    input  wire logic  rst_i,
    fdm_div_if.engine  div_bus
);
    localparam int CNT_W = $clog2(FRAC_W + 1);

    logic [FRAC_W+1:0] rem_ff;
    logic [FRAC_W:0]   den_ff;
    logic [FRAC_W-1:0] quot_ff;
    logic [CNT_W-1:0]  cnt_ff;
    logic              run_ff;
    logic              done_ff;
    logic [FRAC_W+1:0] shifted;
    logic              fits;

    // trial subtract on the doubled remainder
    assign shifted = {rem_ff[FRAC_W:0], 1'b0};
    assign fits    = shifted >= {1'b0, den_ff};

    ////////////////////////////////////////////////////////////////////////
    // remainder and quotient shift
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rem_ff  <= '0;
            den_ff  <= '0;
            quot_ff <= '0;
        end else if (div_bus.start) begin
            rem_ff  <= {1'b0, div_bus.num_mag};
            den_ff  <= div_bus.den_mag;
            quot_ff <= '0;
        end else if (run_ff) begin
            rem_ff  <= fits ? shifted - {1'b0, den_ff} : shifted;
            quot_ff <= {quot_ff[FRAC_W-2:0], fits};
        end
    end

    // step count; start while running restarts the sequence
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cnt_ff  <= '0;
            run_ff  <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (div_bus.start) begin
                cnt_ff <= CNT_W'(FRAC_W);
                run_ff <= 1'b1;
            end else if (run_ff) begin
                cnt_ff <= cnt_ff - CNT_W'(1);
                if (cnt_ff == CNT_W'(1)) begin
                    run_ff  <= 1'b0;
                    done_ff <= 1'b1;
                end
            end
        end
    end

    assign div_bus.done  = done_ff;
    assign div_bus.quot  = quot_ff;
    assign div_bus.exact = (rem_ff == '0);
endmodule : fdm_divider

//--- src/fdm_alu.sv
`include "fdm_consts.svh"

// Summary of operation
// - words are two's complement fractions, minus one valid
// - binary point between sign and first stage
// - divide by zero returns 2 - x - lsb
// - zero over zero returns all ones
// - equal operands give fixed singular quotients
// - opposite equal magnitudes give fixed quotients
// - divisor minus one gives defined quotients
// - one minus-one factor gives 2 - y or |y|
// - minus-one handling symmetric between factors
// - both factors minus one give 1 + lsb
// - exact even quotients of a negative dividend drop by two lsb
module fdm_alu (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    input  wire logic              req_valid_i,
    input  wire fdm_pkg::fdm_op_t  req_op_i,
    input  wire fdm_pkg::fdm_word_t opa_i,
    input  wire fdm_pkg::fdm_word_t opb_i,
    output logic                   busy_o,
    output logic                   res_valid_o,
    output fdm_pkg::fdm_word_t     res_word_o
);
    fdm_pkg::fdm_state_t state_ff;
    fdm_pkg::fdm_op_t    op_ff;
    fdm_pkg::fdm_word_t  opa_ff;       // dividend or multiplicand
    fdm_pkg::fdm_word_t  opb_ff;       // divisor or multiplier
    logic                busy_ff;
    logic                res_valid_ff;
    fdm_pkg::fdm_word_t  res_word_ff;
    logic                accept;
    logic signed [79:0]  mul_prod;
    fdm_pkg::fdm_word_t  mul_word;
    fdm_pkg::fdm_word_t  div_word;

    fdm_div_if #(.FRAC_W(`FDM_FRAC_W)) div_bus ();

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // two's complement negate, wraps modulo two
    function automatic fdm_pkg::fdm_word_t negate(
        input fdm_pkg::fdm_word_t w
    );
        negate = ~w + `FDM_LSB;
    endfunction : negate

    // magnitude; minus one maps to the unsigned value one
    function automatic fdm_pkg::fdm_word_t magnitude(
        input fdm_pkg::fdm_word_t w
    );
        magnitude = w[`FDM_SIGN_BIT] ? negate(w) : w;
    endfunction : magnitude

    function automatic logic is_neg_one(input fdm_pkg::fdm_word_t w);
        is_neg_one = (w == `FDM_NEG_ONE);
    endfunction : is_neg_one

    // quotient word for divisor y, with singular cases ahead of the
    // general magnitude result
    function automatic fdm_pkg::fdm_word_t div_result(
        input fdm_pkg::fdm_word_t x,
        input fdm_pkg::fdm_word_t y,
        input logic [`FDM_FRAC_W-1:0] q,
        input logic exact
    );
        fdm_pkg::fdm_word_t qm;
        fdm_pkg::fdm_word_t qa;
        logic               even_exact;
        qm         = {1'b0, q};
        even_exact = exact && !q[0];
        qa         = even_exact ? qm - `FDM_EXACT_ADJ : qm;
        if (y == `FDM_ZERO) begin
            div_result = ~x;
        end else if (is_neg_one(y)) begin
            div_result = x[`FDM_SIGN_BIT] ? x - `FDM_LSB : ~x;
        end else if (x == y) begin
            div_result = x[`FDM_SIGN_BIT] ? `FDM_POS_MAX
                                          : `FDM_NEG_UNIT;
        end else if (x == negate(y)) begin
            div_result = x[`FDM_SIGN_BIT] ? `FDM_NEG_UNIT
                                          : `FDM_POS_MAX;
        end else begin
            // general path; sign pairs decide the exact-case shift
            case ({x[`FDM_SIGN_BIT], y[`FDM_SIGN_BIT]})
                2'b00: div_result = qm;
                2'b11: div_result = qa;
                2'b10: div_result = negate(qa);
                2'b01: div_result = negate(qm);
                default: div_result = qm;
            endcase
        end
    endfunction : div_result

    ////////////////////////////////////////////////////////////////////////
    // multiply: product of fractions has two sign stages, keep one

    assign mul_prod = $signed(opa_ff) * $signed(opb_ff);

    always_comb begin
        if (is_neg_one(opa_ff) && is_neg_one(opb_ff)) begin
            mul_word = `FDM_NEG_UNIT;
        end else if (is_neg_one(opa_ff)) begin
            // 2 - y and |y| both reduce to the negated word
            mul_word = opb_ff[`FDM_SIGN_BIT] ? magnitude(opb_ff)
                                             : negate(opb_ff);
        end else if (is_neg_one(opb_ff)) begin
            mul_word = opa_ff[`FDM_SIGN_BIT] ? magnitude(opa_ff)
                                             : negate(opa_ff);
        end else begin
            mul_word = mul_prod[78:39];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // divider hookup; a minus-one dividend gives a meaningless general
    // quotient, which the issuing control must not use
    assign div_bus.start   = (state_ff == fdm_pkg::FDM_ST_DSTART);
    assign div_bus.num_mag = magnitude(opa_ff);
    assign div_bus.den_mag = magnitude(opb_ff);

    assign div_word = div_result(opa_ff, opb_ff, div_bus.quot,
                                 div_bus.exact);

    fdm_divider #(
        .FRAC_W    (`FDM_FRAC_W)
    ) u_divider (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .div_bus   (div_bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // request capture; operands stand still until the next accepted request
    assign accept = req_valid_i && !busy_ff;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            op_ff  <= fdm_pkg::FDM_OP_MUL;
            opa_ff <= `FDM_ZERO;
            opb_ff <= `FDM_ZERO;
        end else if (accept) begin
            op_ff  <= req_op_i;
            opa_ff <= opa_i;
            opb_ff <= opb_i;
        end
    end

    // sequencing of one operation at a time
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_ff <= fdm_pkg::FDM_ST_IDLE;
            busy_ff  <= 1'b0;
        end else begin
            case (state_ff)
                fdm_pkg::FDM_ST_IDLE: begin
                    if (accept) begin
                        busy_ff  <= 1'b1;
                        state_ff <= (req_op_i == fdm_pkg::FDM_OP_DIV)
                                    ? fdm_pkg::FDM_ST_DSTART
                                    : fdm_pkg::FDM_ST_MUL;
                    end
                end
                fdm_pkg::FDM_ST_MUL: begin
                    busy_ff  <= 1'b0;
                    state_ff <= fdm_pkg::FDM_ST_IDLE;
                end
                fdm_pkg::FDM_ST_DSTART: begin
                    state_ff <= fdm_pkg::FDM_ST_DWAIT;
                end
                fdm_pkg::FDM_ST_DWAIT: begin
                    if (div_bus.done) begin
                        busy_ff  <= 1'b0;
                        state_ff <= fdm_pkg::FDM_ST_IDLE;
                    end
                end
                default: begin
                    busy_ff  <= 1'b0;
                    state_ff <= fdm_pkg::FDM_ST_IDLE;
                end
            endcase
        end
    end

    // result register; the word holds until the next result
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            res_valid_ff <= 1'b0;
            res_word_ff  <= `FDM_ZERO;
        end else begin
            res_valid_ff <= 1'b0;
            if (state_ff == fdm_pkg::FDM_ST_MUL) begin
                res_valid_ff <= 1'b1;
                res_word_ff  <= mul_word;
            end else if (state_ff == fdm_pkg::FDM_ST_DWAIT &&
                         div_bus.done) begin
                res_valid_ff <= 1'b1;
                res_word_ff  <= div_word;
            end
        end
    end

    assign busy_o      = busy_ff;
    assign res_valid_o = res_valid_ff;
    assign res_word_o  = res_word_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    logic div_done;
    logic mul_done;
    assign div_done = res_valid_o && op_ff == fdm_pkg::FDM_OP_DIV;
    assign mul_done = res_valid_o && op_ff == fdm_pkg::FDM_OP_MUL;

    neg_one_word_a: assert property (
        div_done && opa_ff == 40'h80_0000_0000 && opb_ff == 40'h00_0000_0000
        |-> res_word_o == 40'h7F_FFFF_FFFF)
        else $error("minus one over zero gave wrong word");

    binary_point_a: assert property (
        mul_done && opa_ff == 40'h40_0000_0000 && opb_ff == 40'h40_0000_0000
        |-> res_word_o == 40'h20_0000_0000)
        else $error("half times half is not a quarter");

    div_zero_a: assert property (
        div_done && opb_ff == 40'h00_0000_0000 |-> res_word_o == ~opa_ff)
        else $error("divide by zero word wrong");

    zero_zero_a: assert property (
        div_done && opa_ff == 40'h0 && opb_ff == 40'h0
        |-> res_word_o == 40'hFF_FFFF_FFFF)
        else $error("zero over zero not all ones");

    equal_ops_a: assert property (
        div_done && opa_ff == opb_ff && opb_ff != 40'h0
        && opb_ff != 40'h80_0000_0000
        |-> res_word_o == (opa_ff[39] ? 40'h7F_FFFF_FFFF
                                      : 40'h80_0000_0001))
        else $error("equal operand quotient wrong");

    opposite_ops_a: assert property (
        div_done && opa_ff == -opb_ff && opb_ff != 40'h0
        && opb_ff != 40'h80_0000_0000
        |-> res_word_o == (opa_ff[39] ? 40'h80_0000_0001
                                      : 40'h7F_FFFF_FFFF))
        else $error("opposite operand quotient wrong");

    div_neg_one_a: assert property (
        div_done && opb_ff == 40'h80_0000_0000
        |-> res_word_o == (opa_ff[39] ? opa_ff - 40'h1 : ~opa_ff))
        else $error("divide by minus one wrong");

    mul_neg_one_a: assert property (
        mul_done && opa_ff == 40'h80_0000_0000
        && opb_ff != 40'h80_0000_0000 |-> res_word_o == -opb_ff)
        else $error("minus one multiplicand wrong");

    mul_symmetry_a: assert property (
        mul_done && opb_ff == 40'h80_0000_0000
        && opa_ff != 40'h80_0000_0000 |-> res_word_o == -opa_ff)
        else $error("minus one multiplier not symmetric");

    both_neg_one_a: assert property (
        mul_done && opa_ff == 40'h80_0000_0000
        && opb_ff == 40'h80_0000_0000 |-> res_word_o == 40'h80_0000_0001)
        else $error("minus one squared wrong");

    div_latency_a: assert property (
        accept && req_op_i == fdm_pkg::FDM_OP_DIV
        |=> busy_o [*8] ##[33:34] res_valid_o)
        else $error("division latency wrong");

    mul_latency_a: assert property (
        accept && req_op_i == fdm_pkg::FDM_OP_MUL
        |=> busy_o ##1 (res_valid_o && !busy_o))
        else $error("multiply latency wrong");

    exact_neg_a: assert property (
        div_done && opa_ff == 40'hF0_0000_0000
        && opb_ff == 40'hC0_0000_0000
        |-> res_word_o == 40'h1F_FFFF_FFFE)
        else $error("negated exact quotient not shifted");

    // a strobe while busy is refused and leaves the operands of the running order alone
    busy_hold_a: assert property (
        busy_o && req_valid_i |=> $stable(opa_ff) && $stable(opb_ff))
        else $error("request taken while busy");

    cov_div_zero: cover property (div_done && opb_ff == 40'h0);
    cov_mul_neg: cover property (mul_done && opa_ff == 40'h80_0000_0000);
    cov_exact: cover property (state_ff == fdm_pkg::FDM_ST_DWAIT
        && div_bus.done && div_bus.exact && opa_ff[39] && opb_ff[39]);
    cov_mul_both: cover property (mul_done && opa_ff == 40'h80_0000_0000
        && opb_ff == 40'h80_0000_0000);
    cov_div_neg: cover property (div_done && opb_ff == 40'h80_0000_0000);
endmodule : fdm_alu

//--- bench/fdm_ctrl_model.sv
// issuing control: one order at a time, inputs changed at the falling edge
module fdm_ctrl_model (
    input  wire logic               clk_sys_i,
    input  wire logic               busy_i,
    input  wire logic               res_valid_i,
    input  wire fdm_pkg::fdm_word_t res_word_i,
    output logic                    req_valid_o,
    output fdm_pkg::fdm_op_t        req_op_o,
    output fdm_pkg::fdm_word_t      opa_o,
    output fdm_pkg::fdm_word_t      opb_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        req_valid_o = 1'b0;
        req_op_o    = fdm_pkg::FDM_OP_MUL;
        opa_o       = 40'h00_0000_0000;
        opb_o       = 40'h00_0000_0000;
    end

    // issue one order and collect its word; spur pokes a stray strobe
    // while the block is busy, which it must ignore
    // the caller never relies on a quotient of a minus-one dividend
    // unless the divisor is zero or minus one
    task automatic run(
        input  fdm_pkg::fdm_op_t   op,
        input  fdm_pkg::fdm_word_t a,
        input  fdm_pkg::fdm_word_t b,
        input  bit                 spur,
        output fdm_pkg::fdm_word_t res,
        output int                 lat,
        output int                 nb
    );
        int n;
        @(negedge clk_sys_i);
        req_valid_o = 1'b1;
        req_op_o    = op;
        opa_o       = a;
        opb_o       = b;
        // accepted at this edge: we only issue while the block is idle
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        req_valid_o = 1'b0;
        // released operand lines show garbage, not the old value
        opa_o       = ~a;
        opb_o       = ~b;
        lat         = 0;
        res         = 40'h00_0000_0000;
        nb          = 0;
        for (n = 1; n <= 60 && lat == 0; n++) begin
            // busy must stand from the cycle after the take to the answer
            if (busy_i === 1'b1) begin
                nb++;
            end
            if (res_valid_i === 1'b1) begin
                lat = n;
                res = res_word_i;
            end else if (spur && n == 5) begin
                req_valid_o = 1'b1;
                req_op_o    = fdm_pkg::FDM_OP_MUL;
            end else if (spur && n == 6) begin
                req_valid_o = 1'b0;
            end
            if (lat == 0) begin
                @(negedge clk_sys_i);
            end
        end
    endtask : run
endmodule : fdm_ctrl_model

//--- bench/tb_top.sv
`include "fdm_consts.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic               clk_sys_i;
    logic               rst_i;
    logic               req_valid;
    fdm_pkg::fdm_op_t   req_op;
    fdm_pkg::fdm_word_t opa;
    fdm_pkg::fdm_word_t opb;
    logic               busy;
    logic               res_valid;
    fdm_pkg::fdm_word_t res_word;
    int                 n_mismatch;
    int                 checks;

    fdm_alu u_fdm_alu (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .req_valid_i (req_valid),
        .req_op_i    (req_op),
        .opa_i       (opa),
        .opb_i       (opb),
        .busy_o      (busy),
        .res_valid_o (res_valid),
        .res_word_o  (res_word)
    );

    fdm_ctrl_model u_fdm_ctrl_model (
        .clk_sys_i   (clk_sys_i),
        .busy_i      (busy),
        .res_valid_i (res_valid),
        .res_word_i  (res_word),
        .req_valid_o (req_valid),
        .req_op_o    (req_op),
        .opa_o       (opa),
        .opb_o       (opb)
    );

    // 125 MHz
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // comparison and verdict

    task automatic check(input fdm_pkg::fdm_word_t seen,
                         input fdm_pkg::fdm_word_t exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    // one order, its word and its fixed latency (2 mul, 42 div)
    task automatic do_op(input fdm_pkg::fdm_op_t   op,
                         input fdm_pkg::fdm_word_t a,
                         input fdm_pkg::fdm_word_t b,
                         input fdm_pkg::fdm_word_t exp,
                         input int                 spur);
        fdm_pkg::fdm_word_t res;
        int                 lat;
        int                 nb;
        int                 want;
        want = (op == fdm_pkg::FDM_OP_MUL) ? 2 : 42;
        u_fdm_ctrl_model.run(op, a, b, spur != 0, res, lat, nb);
        check(res, exp);
        check(40'(lat), 40'(want));
        // busy in every cycle but the answer's, low again with it
        check(40'(nb), 40'(want - 1));
        check({39'h0, busy}, `FDM_ZERO);
    endtask : do_op

    ////////////////////////////////////////////////////////////////////////
    // scenarios

    localparam fdm_pkg::fdm_op_t DV = fdm_pkg::FDM_OP_DIV;
    localparam fdm_pkg::fdm_op_t ML = fdm_pkg::FDM_OP_MUL;

    task automatic t_div_zero();
        fdm_pkg::fdm_word_t z;
        z = `FDM_ZERO;
        do_op(DV, 40'h12_3456_789A, z, 40'hED_CBA9_8765, 0);
        do_op(DV, `FDM_NEG_ONE, z, `FDM_POS_MAX, 0);
        do_op(DV, 40'hC0_0000_0000, z, 40'h3F_FFFF_FFFF, 0);
        do_op(DV, z, z, `FDM_ALL_ONES, 0);
    endtask : t_div_zero

    task automatic t_div_equal();
        fdm_pkg::fdm_word_t p;
        fdm_pkg::fdm_word_t m;
        p = 40'h20_0000_0000;
        m = 40'hE0_0000_0000;
        do_op(DV, p, p, `FDM_NEG_UNIT, 0);
        do_op(DV, m, m, `FDM_POS_MAX, 0);
        do_op(DV, p, m, `FDM_POS_MAX, 0);
        do_op(DV, m, p, `FDM_NEG_UNIT, 0);
    endtask : t_div_equal

    task automatic t_div_neg_one();
        fdm_pkg::fdm_word_t n1;
        n1 = `FDM_NEG_ONE;
        do_op(DV, 40'h30_0000_0000, n1, 40'hCF_FFFF_FFFF, 0);
        do_op(DV, 40'hD0_0000_0000, n1, 40'hCF_FFFF_FFFF, 0);
        do_op(DV, `FDM_ZERO, n1, `FDM_ALL_ONES, 0);
        do_op(DV, n1, n1, `FDM_POS_MAX, 0);
    endtask : t_div_neg_one

    // minus one as either factor: 2 - y for y >= 0, |y| for y < 0
    task automatic t_mul_neg_one();
        fdm_pkg::fdm_word_t ys [4];
        fdm_pkg::fdm_word_t e;
        ys = '{40'h30_0000_0000, 40'h00_0000_0000,
               40'hD0_0000_0000, `FDM_POS_MAX};
        foreach (ys[i]) begin
            e = 40'(40'h00_0000_0000 - ys[i]);
            do_op(ML, `FDM_NEG_ONE, ys[i], e, 0);
            do_op(ML, ys[i], `FDM_NEG_ONE, e, 0);
        end
        do_op(ML, `FDM_NEG_ONE, `FDM_NEG_ONE, `FDM_NEG_UNIT, 0);
    endtask : t_mul_neg_one

    // 1/8 over 1/2 is exact in two quotient bits
    task automatic t_exact();
        fdm_pkg::fdm_word_t x;
        fdm_pkg::fdm_word_t y;
        fdm_pkg::fdm_word_t q;
        x = 40'h10_0000_0000;
        y = 40'h40_0000_0000;
        q = 40'h20_0000_0000;
        do_op(DV, x, y, q, 0);
        do_op(DV, -x, -y, q - `FDM_EXACT_ADJ, 0);
        do_op(DV, -x, y, -(q - `FDM_EXACT_ADJ), 0);
        do_op(DV, x, -y, -q, 0);
    endtask : t_exact

    // ordinary fractions, binary point after the sign stage
    task automatic t_general();
        do_op(ML, 40'h40_0000_0000, 40'h40_0000_0000,
              40'h20_0000_0000, 0);
        do_op(ML, 40'h40_0000_0000, 40'hC0_0000_0000,
              40'hE0_0000_0000, 0);
        do_op(ML, `FDM_LSB, `FDM_POS_MAX, `FDM_ZERO, 0);
    endtask : t_general

    // a stray strobe in mid-divide must not disturb the quotient
    task automatic t_refused();
        do_op(DV, 40'h10_0000_0000, 40'h40_0000_0000,
              40'h20_0000_0000, 1);
    endtask : t_refused

    ////////////////////////////////////////////////////////////////////////
    // sequence and watchdog

    initial begin
        n_mismatch = 0;
        checks     = 0;
        rst_i      = 1'b1;
        repeat (16) @(negedge clk_sys_i);
        check({38'h0, busy, res_valid}, `FDM_ZERO);
        check(res_word, `FDM_ZERO);
        rst_i = 1'b0;
        t_div_zero();
        t_div_equal();
        t_div_neg_one();
        t_mul_neg_one();
        t_exact();
        t_general();
        t_refused();
        end_of_test();
    end

    // 29 orders of at most 45 cycles each
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        n_mismatch++;
        end_of_test();
    end
endmodule : tb_top
